// >>> bit_test_compare_instr_exec.v
// Bit test, compare, skip, branch and call execution unit behind an AHB-Lite slave.
//
// Contract
// [RULE1] flag_to_bit_write copies carry or zero into the selected bit, one cycle.
// [RULE2] test_skip_if_clear skips when bit is zero; 1 cycle, 2 or 3 skipping.
// [RULE3] test_skip_if_set skips when bit is one; flags stay unchanged.
// [RULE4] bit_test_op reports the bit in carry or zero; only that flag changes.
// [RULE5] bit_test_and_set_op tests into a flag, then sets the bit, one cycle.
// [RULE6] Calls take 4 cycles; literal form 2 words; all forms update stack frame flag.
// [RULE7] compare_op subtracts without storing, updating five arithmetic flags.
// [RULE8] compare_with_zero_op compares the operand with 0x0000, updating five flags.
// [RULE9] compare_with_borrow_op subtracts second operand and borrow, updates five flags.
// [RULE10] File form of compare with borrow uses the default work register.
// [RULE11] Compare skips test equal, greater, less, unequal; 1, or 2 or 3 cycles.
// [RULE12] Compare branches take 1 cycle not taken, 5 taken; flags unchanged.
// [RULE13] Reading a non-core special register costs one extra cycle.
// [RULE14] A taken skip costs 2 cycles over one word, 3 over two words.
`timescale 1ns/10ps
`include "exec_consts.vh"
module bit_test_compare_instr_exec
(
   input  wire        hclk,
   input  wire        hresetn,
   input  wire        hsel,
   input  wire [31:0] haddr,
   input  wire [1:0]  htrans,
   input  wire        hwrite,
   input  wire [2:0]  hsize,
   input  wire        hready,
   input  wire [31:0] hwdata,
   output reg  [31:0] hrdata,
   output reg         hreadyout,
   output reg         hresp
);
   localparam [1:0] ST_IDLE = 2'b01;
   localparam [1:0] ST_BUSY = 2'b10;

   reg  [1:0]  state;
   reg  [3:0]  cnt;
   reg  [15:0] opa;
   reg  [15:0] opb;
   reg  [15:0] default_work_register;
   reg  [3:0]  bitsel;
   reg  [5:0]  status;
   reg  [15:0] result;
   reg  [22:0] target;
   reg         skip_taken;
   reg         branch_taken;
   reg  [3:0]  cycles_used;
   reg  [1:0]  words_used;
   reg         wr_pend;
   reg         rd_pend;
   reg  [7:0]  acc_addr;

   reg  [15:0] cmp_b;
   reg         cmp_cin;
   reg  [5:0]  next_status;
   reg  [15:0] next_result;
   reg         next_skip;
   reg         next_branch;
   reg  [3:0]  next_cycles;
   reg  [1:0]  next_words;
   reg  [31:0] rd_mux;

   wire [4:0]  op      = hwdata[`CTRL_OP_MSB:`CTRL_OP_LSB];
   wire        suf_z   = hwdata[`CTRL_SUFZ];
   wire        use_wb  = hwdata[`CTRL_USE_WB];
   wire        file_f  = hwdata[`CTRL_FILE];
   wire        lit_f   = hwdata[`CTRL_LIT];
   wire        noncpu  = hwdata[`CTRL_NONCPU];
   wire        next2w  = hwdata[`CTRL_NEXT2W];
   wire        call_lt = hwdata[`CTRL_CALL_LIT];
   wire        addr_ok = hsel & hready & htrans[1];
   wire        exec_go = wr_pend & (acc_addr == `OFS_CTRL) & (state == ST_IDLE);
   wire [3:0]  pos     = use_wb ? opb[3:0] : bitsel;
   wire [15:0] mask;
   wire        tbit    = |(opa & mask);
   wire [15:0] diff;
   wire        f_c;
   wire        f_dc;
   wire        f_n;
   wire        f_ov;
   wire        f_z;
   wire        f_eq;
   wire        f_gt;
   wire        f_lt;

   genvar i;
   generate
      for (i = 0; i < 16; i = i + 1)
      begin : g_mask
         assign mask[i] = (pos == i);
      end
   endgenerate

   compare_unit u_cmp
   (
      .a    (opa),
      .b    (cmp_b),
      .cin  (cmp_cin),
      .diff (diff),
      .c    (f_c),
      .dc   (f_dc),
      .n    (f_n),
      .ov   (f_ov),
      .z    (f_z),
      .eq   (f_eq),
      .gt   (f_gt),
      .lt   (f_lt)
   );

   always @*
   begin
      cmp_b   = opb;
      cmp_cin = 1'b1;
      case (op)
         `OP_CP:
            cmp_b = file_f ? default_work_register : (lit_f ? {8'h00, opb[7:0]} : opb);
         // [RULE8] compare against zero
         `OP_CP0:
            cmp_b = 16'h0000;
         // [RULE9] borrow from carry
         `OP_CPB:
         begin
            // [RULE10] file form uses work register
            cmp_b   = file_f ? default_work_register : (lit_f ? {8'h00, opb[7:0]} : opb);
            cmp_cin = status[`ST_C];
         end
         default:
            cmp_b = opb;
      endcase
   end

   always @*
   begin
      next_status = status;
      next_result = opa;
      next_skip   = 1'b0;
      next_branch = 1'b0;
      next_cycles = `CYC_BASE;
      next_words  = 2'h1;
      case (op)
         // [RULE1] flag into bit
         `OP_BSW:
            next_result = (opa & ~mask) | (mask & {16{suf_z ? status[`ST_Z] : status[`ST_C]}});
         `OP_BTG:
            next_result = opa ^ mask;
         // [RULE2] skip when clear
         `OP_TEST_SKIP_IF_CLEAR:
            next_skip = ~tbit;
         // [RULE3] skip when set
         `OP_TEST_SKIP_IF_SET:
            next_skip = tbit;
         // [RULE4] single flag report
         `OP_BIT_TEST_OP:
            if (suf_z | file_f)
               next_status[`ST_Z] = ~tbit;
            else
               next_status[`ST_C] = tbit;
         // [RULE5] test then set
         `OP_BIT_TEST_AND_SET_OP:
         begin
            if (suf_z | file_f)
               next_status[`ST_Z] = ~tbit;
            else
               next_status[`ST_C] = tbit;
            next_result = opa | mask;
         end
         // [RULE6] call timing and frame flag
         `OP_CALL:
         begin
            next_cycles = `CYC_CALL;
            next_words  = call_lt ? 2'h2 : 2'h1;
            next_branch = 1'b1;
            next_status[`ST_SFA] = 1'b0;
         end
         // [RULE7] five flag compare
         `OP_CP, `OP_CP0, `OP_CPB:
         begin
            next_status[`ST_C]  = f_c;
            next_status[`ST_DC] = f_dc;
            next_status[`ST_N]  = f_n;
            next_status[`ST_OV] = f_ov;
            next_status[`ST_Z]  = (op == `OP_CPB) ? (f_z & status[`ST_Z]) : f_z;
         end
         // [RULE11] compare and skip
         `OP_SEQ:
            next_skip = f_eq;
         `OP_SGT:
            next_skip = f_gt;
         `OP_SLT:
            next_skip = f_lt;
         `OP_SNE:
            next_skip = ~f_eq;
         // [RULE12] compare and branch
         `OP_BEQ:
            next_branch = f_eq;
         `OP_BGT:
            next_branch = f_gt;
         `OP_BLT:
            next_branch = f_lt;
         `OP_BNE:
            next_branch = ~f_eq;
         default:
            next_result = opa;
      endcase
      // [RULE14] skip length by word count
      if (next_skip)
         next_cycles = next2w ? `CYC_SKIP2W : `CYC_SKIP1W;
      if (next_branch & (op != `OP_CALL))
         next_cycles = `CYC_BRANCH;
      // [RULE13] extra cycle for peripheral register
      if (noncpu & file_f)
         next_cycles = next_cycles + `CYC_SFR_EXTRA;
   end

   always @*
   begin
      rd_mux = 32'h00000000;
      case (acc_addr)
         `OFS_OPA:
            rd_mux = {16'h0000, opa};
         `OFS_OPB:
            rd_mux = {16'h0000, opb};
         `OFS_DEFAULT_WORK_REGISTER:
            rd_mux = {16'h0000, default_work_register};
         `OFS_BITSEL:
            rd_mux = {28'h0000000, bitsel};
         `OFS_STATUS:
            rd_mux = {26'h0000000, status};
         `OFS_RESULT:
            rd_mux = {16'h0000, result};
         `OFS_INFO:
            rd_mux = {22'h000000, words_used, cycles_used, 1'b0, branch_taken, skip_taken,
                      (state == ST_BUSY)};
         `OFS_TARGET:
            rd_mux = {9'h000, target};
         default:
            rd_mux = 32'h00000000;
      endcase
   end

   // Bus side: writes take effect at the end of the data phase, reads add one wait state.
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         wr_pend   <= 1'b0;
         rd_pend   <= 1'b0;
         acc_addr  <= 8'h00;
         hrdata    <= 32'h00000000;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end
      else
      begin
         hresp <= 1'b0;
         if (rd_pend)
         begin
            hrdata    <= rd_mux;
            hreadyout <= 1'b1;
            rd_pend   <= 1'b0;
            wr_pend   <= 1'b0;
         end
         else
         begin
            wr_pend <= addr_ok & hwrite;
            if (addr_ok)
               acc_addr <= haddr[7:0];
            if (addr_ok & ~hwrite)
            begin
               rd_pend   <= 1'b1;
               hreadyout <= 1'b0;
            end
         end
      end
   end

   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         state                 <= ST_IDLE;
         cnt                   <= 4'h0;
         opa                   <= `RST_WORD;
         opb                   <= `RST_WORD;
         default_work_register <= `RST_WORD;
         bitsel                <= 4'h0;
         status                <= `RST_STATUS;
         result                <= `RST_WORD;
         target                <= 23'h000000;
         skip_taken            <= 1'b0;
         branch_taken          <= 1'b0;
         cycles_used           <= 4'h0;
         words_used            <= 2'h0;
      end
      else
      begin
         case (state)
            ST_IDLE:
               if (exec_go)
               begin
                  status       <= next_status;
                  result       <= next_result;
                  skip_taken   <= next_skip;
                  branch_taken <= next_branch;
                  cycles_used  <= next_cycles;
                  words_used   <= next_words;
                  cnt          <= next_cycles - 4'h1;
                  if (next_cycles != 4'h1)
                     state <= ST_BUSY;
               end
            ST_BUSY:
            begin
               cnt <= cnt - 4'h1;
               if (cnt == 4'h1)
                  state <= ST_IDLE;
            end
            default:
               state <= ST_IDLE;
         endcase
         if (wr_pend)
         begin
            case (acc_addr)
               `OFS_OPA:
                  opa <= hwdata[15:0];
               `OFS_OPB:
                  opb <= hwdata[15:0];
               `OFS_DEFAULT_WORK_REGISTER:
                  default_work_register <= hwdata[15:0];
               `OFS_BITSEL:
                  bitsel <= hwdata[3:0];
               `OFS_STATUS:
                  if (state == ST_IDLE)
                     status <= hwdata[5:0];
               `OFS_TARGET:
                  target <= hwdata[22:0];
               default:
                  ;
            endcase
         end
      end
   end
endmodule

// >>> exec_consts.vh
// Offsets, control fields, opcodes, reset values and cycle counts of the execution block.
`ifndef EXEC_CONSTS_VH
`define EXEC_CONSTS_VH

`define OFS_CTRL        8'h00
`define OFS_OPA         8'h04
`define OFS_OPB         8'h08
`define OFS_DEFAULT_WORK_REGISTER        8'h0C
`define OFS_BITSEL      8'h10
`define OFS_STATUS      8'h14
`define OFS_RESULT      8'h18
`define OFS_INFO        8'h1C
`define OFS_TARGET      8'h20

`define CTRL_OP_MSB     4
`define CTRL_OP_LSB     0
`define CTRL_SUFZ       8
`define CTRL_USE_WB     9
`define CTRL_FILE       10
`define CTRL_LIT        11
`define CTRL_NONCPU     12
`define CTRL_NEXT2W     13
`define CTRL_CALL_LIT   14

`define ST_C            0
`define ST_Z            1
`define ST_N            2
`define ST_OV           3
`define ST_DC           4
`define ST_SFA          5

`define INFO_BUSY       0
`define INFO_SKIP       1
`define INFO_BRANCH     2
`define INFO_CYC_LSB    4
`define INFO_WORDS_LSB  8

`define OP_BSW          5'h00
`define OP_BTG          5'h01
`define OP_TEST_SKIP_IF_CLEAR         5'h02
`define OP_TEST_SKIP_IF_SET         5'h03
`define OP_BIT_TEST_OP         5'h04
`define OP_BIT_TEST_AND_SET_OP        5'h05
`define OP_CALL         5'h06
`define OP_CP           5'h07
`define OP_CP0          5'h08
`define OP_CPB          5'h09
`define OP_SEQ          5'h0A
`define OP_SGT          5'h0B
`define OP_SLT          5'h0C
`define OP_SNE          5'h0D
`define OP_BEQ          5'h0E
`define OP_BGT          5'h0F
`define OP_BLT          5'h10
`define OP_BNE          5'h11

`define RST_STATUS      6'h00
`define RST_WORD        16'h0000

`define CYC_BASE        4'h1
`define CYC_SKIP1W      4'h2
`define CYC_SKIP2W      4'h3
`define CYC_CALL        4'h4
`define CYC_BRANCH      4'h5
`define CYC_SFR_EXTRA   4'h1

`endif

// >>> compare_unit.v
// Subtractor and comparator shared by all compare and branch operations.
`timescale 1ns/10ps
module compare_unit
(
   input  wire [15:0] a,
   input  wire [15:0] b,
   input  wire        cin,
   output wire [15:0] diff,
   output wire        c,
   output wire        dc,
   output wire        n,
   output wire        ov,
   output wire        z,
   output wire        eq,
   output wire        gt,
   output wire        lt
);
   wire [16:0] sum;
   wire [4:0]  low;

   assign sum  = {1'b0, a} + {1'b0, ~b} + {16'h0000, cin};
   assign low  = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + {4'h0, cin};
   assign diff = sum[15:0];
   assign c    = sum[16];
   assign dc   = low[4];
   assign n    = diff[15];
   assign ov   = (a[15] ^ b[15]) & (diff[15] ^ a[15]);
   assign z    = (diff == 16'h0000);
   assign eq   = (a == b);
   assign gt   = ($signed(a) > $signed(b));
   assign lt   = ($signed(a) < $signed(b));
endmodule

// >>> exec_bus_chk_asserts.sv
// Bus timing and read-value checks for the execution unit.
`timescale 1ns/10ps
module exec_bus_chk
(
   input wire        hclk,
   input wire        hresetn,
   input wire        hsel,
   input wire [31:0] haddr,
   input wire [1:0]  htrans,
   input wire        hwrite,
   input wire        hready,
   input wire [31:0] hrdata,
   input wire        hreadyout,
   input wire        hresp
);
   wire acc;
   assign acc = hsel & hready & htrans[1];
   default clocking @(posedge hclk);
   endclocking
   default disable iff (!hresetn);
   sequence rd_s;
      acc && !hwrite;
   endsequence
   sequence wait_s;
      !hreadyout ##1 hreadyout;
   endsequence
   one_wait_a: assert property (rd_s |=> wait_s)
      else $error("read wait state wrong");
   wr_nowait_a: assert property (acc && hwrite |=> hreadyout)
      else $error("write stalled");
   ok_resp_a: assert property (hresp == 1'b0)
      else $error("error response seen");
   lone_wait_a: assert property (!hreadyout |-> $past(acc && !hwrite))
      else $error("stall without read");
   data_hold_a: assert property (!$stable(hrdata) |-> $past(!hreadyout))
      else $error("read data moved");
   ctrl_zero_a: assert property (rd_s ##0 haddr[7:0] == 8'h00 |-> ##2 hrdata == 32'h0)
      else $error("control read not zero");
   unmap_zero_a: assert property (rd_s ##0 haddr[7:0] > 8'h20 |-> ##2 hrdata == 32'h0)
      else $error("unmapped read not zero");
   upper_zero_a: assert property (hrdata[31:23] == 9'h0)
      else $error("upper read bits set");
endmodule
bind bit_test_compare_instr_exec exec_bus_chk chk_u
(
   .hclk      (hclk),
   .hresetn   (hresetn),
   .hsel      (hsel),
   .haddr     (haddr),
   .htrans    (htrans),
   .hwrite    (hwrite),
   .hready    (hready),
   .hrdata    (hrdata),
   .hreadyout (hreadyout),
   .hresp     (hresp)
);

// >>> bit_test_compare_instr_exec_tb_top.sv
// Self-checking bench for the execution unit.
`timescale 1ns/10ps
`include "exec_consts.vh"
module bit_test_compare_instr_exec_tb_top;
   reg          hclk = 0;
   reg          hresetn = 0;
   reg          hsel = 0;
   reg  [31:0]  haddr = 0;
   reg  [1:0]   htrans = 0;
   reg          hwrite = 0;
   reg  [31:0]  hwdata = 0;
   wire [31:0]  hrdata;
   wire         hreadyout;
   wire         hresp;
   int          bad_count = 0;
   int          num_checks = 0;
   int          cyc = 0;
   int          op;
   int          m;
   bit          rd_ph = 0;
   logic [31:0] exp_q[$];
   logic [7:0]  adr_q[$];
   logic [31:0] a, b, st, ctl, es, er, ei, bs, w, tg;
   logic [3:0]  pos, cy;
   logic [1:0]  wd, y;
   logic [15:0] q;
   logic        bt, sk, br, t, x;
   always #4 hclk = ~hclk;
   bit_test_compare_instr_exec dut_u
   (
      .hclk      (hclk),
      .hresetn   (hresetn),
      .hsel      (hsel),
      .haddr     (haddr),
      .htrans    (htrans),
      .hwrite    (hwrite),
      .hsize     (3'h2),
      .hready    (hreadyout),
      .hwdata    (hwdata),
      .hrdata    (hrdata),
      .hreadyout (hreadyout),
      .hresp     (hresp)
   );
   task end_of_test;
      $display("checks %0d errors %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task automatic chk(input logic [7:0] ad, input logic [31:0] e, input logic [31:0] s);
      num_checks++;
      if (s !== e)
      begin
         bad_count++;
         $display("wrong value reg %h exp %h got %h", ad, e, s);
      end
   endtask
   // Registered outputs are read on the falling edge, clear of the sampling edge.
   always @(negedge hclk)
      if (rd_ph && hreadyout)
         chk(adr_q.pop_front(), exp_q.pop_front(), hrdata);
   always @(posedge hclk)
   begin
      cyc++;
      if (cyc == 6000)
      begin
         bad_count++;
         end_of_test;
      end
   end
   task automatic wait_rdy;
      logic r;
      do
      begin
         @(negedge hclk);
         r = hreadyout;
         @(posedge hclk);
      end
      while (!r);
   endtask
   task automatic xfer(input bit w, input logic [7:0] ad, input logic [31:0] d);
      hsel   <= 1'b1;
      haddr  <= {24'h0, ad};
      hwrite <= w;
      htrans <= 2'h2;
      wait_rdy;
      htrans <= 2'h0;
      hwdata <= d;
      rd_ph = !w;
      wait_rdy;
      rd_ph = 0;
   endtask
   task automatic rd(input logic [7:0] ad, input logic [31:0] e);
      exp_q.push_back(e);
      adr_q.push_back(ad);
      xfer(0, ad, 32'h0);
   endtask
   task automatic run;
      xfer(1, `OFS_OPA, a);
      xfer(1, `OFS_OPB, b);
      xfer(1, `OFS_BITSEL, bs);
      xfer(1, `OFS_STATUS, st);
      xfer(1, `OFS_DEFAULT_WORK_REGISTER, w);
      xfer(1, `OFS_TARGET, tg);
      xfer(1, `OFS_CTRL, ctl);
      repeat (6) @(posedge hclk);
      rd(`OFS_STATUS, es);
      rd(`OFS_RESULT, er);
      rd(`OFS_INFO, ei);
      rd(`OFS_DEFAULT_WORK_REGISTER, w);
      rd(`OFS_TARGET, tg & 32'h007FFFFF);
   endtask
   function automatic logic [4:0] sub(input logic [15:0] p, input logic [15:0] q, input logic ci);
      logic [16:0] s;
      logic [4:0]  h;
      s = {1'b0, p} + {1'b0, ~q} + ci;
      h = {1'b0, p[3:0]} + {1'b0, ~q[3:0]} + ci;
      sub = {h[4], (p[15] != q[15]) && (s[15] != p[15]), s[15], s[15:0] == 16'h0, s[16]};
   endfunction
   initial
   begin
      a = $urandom(46377);
      repeat (8) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      rd(`OFS_STATUS, 32'h0);
      rd(`OFS_INFO, 32'h0);
      rd(8'h24, 32'h0);
      xfer(1, `OFS_OPA, a);
      rd(`OFS_OPA, a & 32'hFFFF);
      rd(`OFS_CTRL, 32'h0);
      for (int k = 0; k < 72; k++)
      begin
         op = k % 18;
         a = $urandom & 32'hFFFF;
         b = (k % 4 == 0) ? a : $urandom & 32'hFFFF;
         w = (k % 8 == 1) ? a : $urandom & 32'hFFFF;
         tg = $urandom;
         bs = $urandom & 32'hF;
         st = $urandom & 32'h3F;
         x = (op inside {1, 2, 3, 8}) ? $urandom % 2 : 0;
         // File form compares against the work register, literal form against a low byte.
         y = (op inside {7, 9}) ? $urandom % 3 : 0;
         q = (y == 1) ? w[15:0] : (y == 2) ? {8'h00, b[7:0]} : b[15:0];
         ctl = ($urandom & 32'h6300) | op | (x ? 32'h1400 : 32'h0);
         ctl = ctl | (y == 1 ? 32'h0400 : y == 2 ? 32'h0800 : 32'h0);
         pos = ctl[9] ? b[3:0] : bs[3:0];
         bt = a[pos];
         m = (op - 10) % 4;
         t = m == 0 ? a == b : m == 1 ? $signed(a[15:0]) > $signed(b[15:0]) :
             m == 2 ? $signed(a[15:0]) < $signed(b[15:0]) : a != b;
         es = st;
         er = a;
         cy = 4'h1;
         wd = 2'h1;
         sk = 0;
         br = 0;
         case (op)
            0: er[pos] = ctl[8] ? st[1] : st[0];
            1: er[pos] = ~bt;
            2: sk = !bt;
            3: sk = bt;
            4, 5:
            begin
               if (ctl[8])
                  es[1] = ~bt;
               else
                  es[0] = bt;
               if (op == 5)
                  er[pos] = 1'b1;
            end
            6:
            begin
               es[5] = 1'b0;
               cy = 4'h4;
               wd = ctl[14] ? 2'h2 : 2'h1;
               br = 1;
            end
            7: es[4:0] = sub(a[15:0], q, 1'b1);
            8: es[4:0] = sub(a[15:0], 16'h0, 1'b1);
            9:
            begin
               es[4:0] = sub(a[15:0], q, st[0]);
               es[1] = es[1] & st[1];
            end
            10, 11, 12, 13: sk = t;
            default:
            begin
               br = t;
               cy = t ? 4'h5 : 4'h1;
            end
         endcase
         if (sk)
            cy = ctl[13] ? 4'h3 : 4'h2;
         cy = cy + x;
         ei = {22'h0, wd, cy, 1'b0, br, sk, 1'b0};
         run;
      end
      repeat (4) @(posedge hclk);
      end_of_test;
   end
endmodule
